// ===== pcat_pkg.sv
// shared constants and types for the counter array timebase block
package pcat_pkg;
	// ------------------------------------------------------------
	// register byte offsets
	// ------------------------------------------------------------
	localparam logic [7:0] OFS_CTRL     = 8'h00;
	localparam logic [7:0] OFS_FLAGS    = 8'h04;
	localparam logic [7:0] OFS_CNT_LO   = 8'h08;
	localparam logic [7:0] OFS_CNT_HI   = 8'h0c;
	localparam logic [7:0] OFS_CH_MODE  = 8'h10;
	localparam logic [7:0] OFS_CH_CMP   = 8'h14;
	localparam logic [7:0] OFS_CH_STEP  = 8'h08;
	localparam int         NUM_CH       = 3;
	localparam int         WDT_CH       = 2;

	// ------------------------------------------------------------
	// timebase select codes and prescaler counts
	// ------------------------------------------------------------
	localparam logic [2:0] TB_DIV12 = 3'h0;
	localparam logic [2:0] TB_DIV4  = 3'h1;
	localparam logic [2:0] TB_T0OVF = 3'h2;
	localparam logic [2:0] TB_EXTIN = 3'h3;
	localparam logic [2:0] TB_SYS   = 3'h4;
	localparam logic [2:0] TB_OSC8  = 3'h5;
	localparam logic [3:0] DIV_SLOW_LAST = 4'hb;
	localparam logic [1:0] DIV_FAST_LAST = 2'h3;

	// ------------------------------------------------------------
	// channel mode codes
	// ------------------------------------------------------------
	localparam logic [3:0] CM_OFF      = 4'h0;
	localparam logic [3:0] CM_CAP_RISE = 4'h1;
	localparam logic [3:0] CM_CAP_FALL = 4'h2;
	localparam logic [3:0] CM_CAP_ANY  = 4'h3;
	localparam logic [3:0] CM_SOFT_TMR = 4'h4;
	localparam logic [3:0] CM_FAST_OUT = 4'h5;
	localparam logic [3:0] CM_FREQ_OUT = 4'h6;
	localparam logic [3:0] CM_PWM8     = 4'h7;
	localparam logic [3:0] CM_PWM16    = 4'h8;

	// ------------------------------------------------------------
	// register layouts and reset values
	// ------------------------------------------------------------
	typedef struct packed {
		logic       intermediate_overflow_irq_enable;
		logic [1:0] mid_bit_select;
		logic       run;
		logic       idle_suspend_bit;
		logic       watchdog_mode;
		logic [2:0] timebase_select;
		logic       overflow_irq_enable;
	} pcat_ctrl_t;

	typedef struct packed {
		logic [2:0] channel_event_flag;
		logic       intermediate_overflow_flag;
		logic       counter_overflow_flag;
	} pcat_flags_t;

	typedef struct packed {
		logic       channel_irq_enable;
		logic [3:0] mode;
	} pcat_chcfg_t;

	localparam pcat_ctrl_t  CTRL_RST  = 10'h010;
	localparam pcat_flags_t FLAGS_RST = 5'h00;
	localparam pcat_chcfg_t CHCFG_RST = 5'h00;
endpackage

// ===== pcat_sync.sv
// two-flop synchroniser for pins and foreign-clock levels
module pcat_sync
	import pcat_pkg::*;
#(
	parameter int W = 1
)
(
	// clock and reset
	input  wire logic         sys_clk,
	input  wire logic         rstn,
	// level in and out
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta_reg;

	// first stage feeds only the second
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			meta_reg <= '0;
			q        <= '0;
		end
		else
		begin
			meta_reg <= d;
			q        <= meta_reg;
		end
	end
endmodule

// ===== pcat_chan.sv
// one capture/compare channel sharing the main counter
module pcat_chan
	import pcat_pkg::*;
(
	// clock and reset
	input  wire logic        sys_clk,
	input  wire logic        rstn,
	// counter view
	input  wire logic [15:0] count,
	input  wire logic        fresh,
	// configuration
	input  wire logic [3:0]  mode,
	input  wire logic [15:0] cmp,
	// synchronised pin level
	input  wire logic        pin,
	// results
	output logic             evt,
	output logic             cmp_load,
	output logic [15:0]      cmp_load_val,
	output logic             io_out,
	output logic             io_oe_n
);
	logic pin_d;
	logic io_next;

	// edge and match detection
	wire rise    = pin & ~pin_d;
	wire fall    = ~pin & pin_d;
	wire match16 = fresh & (count == cmp);
	wire match8  = fresh & (count[7:0] == cmp[7:0]);
	wire cap     = ((mode == CM_CAP_RISE) & rise) | ((mode == CM_CAP_FALL) & fall)
		| ((mode == CM_CAP_ANY) & (rise | fall));
	wire cmp_md  = (mode == CM_SOFT_TMR) | (mode == CM_FAST_OUT) | (mode == CM_PWM16)
		| (mode == CM_FREQ_OUT);
	wire drives  = (mode >= CM_FAST_OUT) & (mode <= CM_PWM16);
	wire [7:0] freq_lo = 8'(cmp[7:0] + cmp[15:8]);

	// flag source and compare reload
	assign evt          = cap | (cmp_md & match16) | ((mode == CM_PWM8) & match8);
	assign cmp_load     = cap | ((mode == CM_FREQ_OUT) & match8);
	assign cmp_load_val = cap ? count : {cmp[15:8], freq_lo};

	// output line per mode
	always_comb
	begin
		io_next = io_out;
		case (mode)
			CM_FAST_OUT: io_next = io_out ^ match16;
			CM_FREQ_OUT: io_next = io_out ^ match8;
			CM_PWM8:     io_next = count[7:0] < cmp[7:0];
			CM_PWM16:    io_next = count < cmp;
			default:     io_next = io_out;
		endcase
	end

	// pin history, output flop and drive enable
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			pin_d   <= 1'b0;
			io_out  <= 1'b0;
			io_oe_n <= 1'b1;
		end
		else
		begin
			pin_d   <= pin;
			io_out  <= io_next;
			io_oe_n <= ~drives;
		end
	end
endmodule

// ===== pcat_top.sv
// counter array core: timebase, 16-bit counter, flags and apb registers
// What this block does
// - counter is 16 bits, seen by software as low and high byte registers.
// - reading the low byte latches the high byte for the next high read.
// - reading either counter byte never disturbs counting.
// - a 3-bit field picks the timebase; codes 11x are reserved.
// - external input counts on falling edges, at most half the system rate.
// - the oscillator divided by eight is synchronised before use.
// - wrap from all ones to zero sets the counter overflow flag.
// - overflow flag requests an interrupt only while its enable is set.
// - overflow flag stays set until software clears it.
// - with idle suspend clear, counting continues during processor idle.
// - five flags: main overflow, intermediate overflow, one per channel.
// - every flag sets on its trigger regardless of its enable.
// - each flag has an enable; request is the or of enabled flags.
// - three capture/compare channels share the counter, each with an io line.
// - each channel runs one of eight modes independently.
// - channel 2 starts as watchdog after reset; restricts some register writes.
// - channel flags are not auto-cleared; software clears them.
module pcat_top
	import pcat_pkg::*;
(
	// clock and reset
	input  wire logic        sys_clk,
	input  wire logic        rstn,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// count sources
	input  wire logic        external_count_input,
	input  wire logic        ext_osc_div8,
	input  wire logic        timer0_overflow,
	input  wire logic        cpu_idle,
	// channel io lines
	input  wire logic [2:0]  channel_io_in,
	output logic      [2:0]  channel_io_out,
	output logic      [2:0]  channel_io_oe_n,
	// requests
	output logic             irq,
	output logic             wdt_reset_req
);
	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	pcat_ctrl_t  ctrl_reg;
	pcat_flags_t flags_reg;
	pcat_flags_t flags_next;
	pcat_chcfg_t chcfg_reg [NUM_CH];
	logic [15:0] cmp_reg [NUM_CH];
	logic [15:0] cnt_reg;
	logic [15:0] cnt_next;
	logic [7:0]  snap_reg;
	logic [3:0]  div12_reg;
	logic [1:0]  div4_reg;
	logic        fresh_reg;
	logic        eci_d;
	logic        osc_d;
	logic        eci_s;
	logic        osc_s;
	logic [2:0]  pin_s;
	logic [2:0]  ch_evt;
	logic [31:0] rdata_mux;

	// ------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------
	pcat_sync #(.W(5)) u_sync (
		.sys_clk (sys_clk),
		.rstn    (rstn),
		.d       ({channel_io_in, ext_osc_div8, external_count_input}),
		.q       ({pin_s, osc_s, eci_s})
	);

	// ------------------------------------------------------------
	// apb decode
	// ------------------------------------------------------------
	wire setup   = psel & ~penable;
	wire access  = psel & penable & pready;
	wire wr      = access & pwrite;
	wire rd_set  = setup & ~pwrite;
	wire wdt_on  = ctrl_reg.watchdog_mode;
	wire hit_ctl = paddr == OFS_CTRL;
	wire hit_flg = paddr == OFS_FLAGS;
	wire hit_lo  = paddr == OFS_CNT_LO;
	wire hit_hi  = paddr == OFS_CNT_HI;
	logic [NUM_CH-1:0] hit_md;
	logic [NUM_CH-1:0] hit_cp;
	wire hit_any = hit_ctl | hit_flg | hit_lo | hit_hi | (|hit_md) | (|hit_cp);
	// counter writes are locked out while the watchdog runs
	wire wr_lo   = wr & hit_lo & ~wdt_on;
	wire wr_hi   = wr & hit_hi & ~wdt_on;
	wire cnt_wr  = wr_lo | wr_hi;

	// ------------------------------------------------------------
	// timebase selection
	// ------------------------------------------------------------
	wire eci_fall = ~eci_s & eci_d;
	wire osc_rise = osc_s & ~osc_d;
	logic tick;
	always_comb
	begin
		case (ctrl_reg.timebase_select)
			TB_DIV12: tick = div12_reg == DIV_SLOW_LAST;
			TB_DIV4:  tick = div4_reg == DIV_FAST_LAST;
			TB_T0OVF: tick = timer0_overflow;
			TB_EXTIN: tick = eci_fall;
			TB_SYS:   tick = 1'b1;
			TB_OSC8:  tick = osc_rise;
			default:  tick = 1'b0;
		endcase
	end
	wire halted  = ctrl_reg.idle_suspend_bit & cpu_idle;
	wire advance = tick & ctrl_reg.run & ~halted;

	// ------------------------------------------------------------
	// counter and overflow detection
	// ------------------------------------------------------------
	wire [15:0] mid_mask = 16'((16'h0100 << ctrl_reg.mid_bit_select) - 16'h0001);
	wire cf_evt  = advance & (cnt_reg == 16'hffff);
	wire mid_evt = advance & (&(cnt_reg | ~mid_mask));
	always_comb
	begin
		cnt_next = cnt_reg;
		if (advance)
			cnt_next = 16'(cnt_reg + 16'h0001);
		if (wr_lo)
			cnt_next = {cnt_next[15:8], pwdata[7:0]};
		if (wr_hi)
			cnt_next = {pwdata[7:0], cnt_next[7:0]};
	end

	// prescalers run always, so a timebase switch lands mid-period
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			div12_reg <= '0;
			div4_reg  <= '0;
			eci_d     <= 1'b0;
			osc_d     <= 1'b0;
			cnt_reg   <= '0;
			fresh_reg <= 1'b0;
		end
		else
		begin
			div12_reg <= (div12_reg == DIV_SLOW_LAST) ? 4'h0 : 4'(div12_reg + 4'h1);
			div4_reg  <= 2'(div4_reg + 2'h1);
			eci_d     <= eci_s;
			osc_d     <= osc_s;
			cnt_reg   <= cnt_next;
			fresh_reg <= advance | cnt_wr;
		end
	end

	// ------------------------------------------------------------
	// channels
	// ------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < NUM_CH; g++)
		begin : gen_ch
			logic        ld;
			logic [15:0] ld_val;
			wire  [7:0]  md_ofs = 8'(OFS_CH_MODE + 8'(g) * OFS_CH_STEP);
			wire  [7:0]  cp_ofs = 8'(OFS_CH_CMP + 8'(g) * OFS_CH_STEP);
			// channel 2 mode is frozen while it acts as watchdog; its compare stays writable
			wire         lock   = (g == WDT_CH) & wdt_on;
			assign hit_md[g] = paddr == md_ofs;
			assign hit_cp[g] = paddr == cp_ofs;

			pcat_chan u_chan (
				.sys_clk      (sys_clk),
				.rstn         (rstn),
				.count        (cnt_reg),
				.fresh        (fresh_reg),
				.mode         (chcfg_reg[g].mode),
				.cmp          (cmp_reg[g]),
				.pin          (pin_s[g]),
				.evt          (ch_evt[g]),
				.cmp_load     (ld),
				.cmp_load_val (ld_val),
				.io_out       (channel_io_out[g]),
				.io_oe_n      (channel_io_oe_n[g])
			);

			// hardware capture beats a software write in the same cycle
			always_ff @(posedge sys_clk or negedge rstn)
			begin
				if (!rstn)
				begin
					chcfg_reg[g] <= CHCFG_RST;
					cmp_reg[g]   <= '0;
				end
				else
				begin
					if (wr & hit_md[g] & ~lock)
						chcfg_reg[g] <= pwdata[4:0];
					if (ld)
						cmp_reg[g] <= ld_val;
					else if (wr & hit_cp[g])
						cmp_reg[g] <= pwdata[15:0];
				end
			end
		end
	endgenerate

	// ------------------------------------------------------------
	// flags and interrupt request
	// ------------------------------------------------------------
	wire [4:0] flag_set = {ch_evt, mid_evt, cf_evt};
	wire [4:0] flag_clr = (wr & hit_flg) ? pwdata[4:0] : 5'h00;
	wire [4:0] flag_en  = {chcfg_reg[2].channel_irq_enable, chcfg_reg[1].channel_irq_enable,
		chcfg_reg[0].channel_irq_enable, ctrl_reg.intermediate_overflow_irq_enable,
		ctrl_reg.overflow_irq_enable};
	// write one to clear; a same-cycle set wins
	assign flags_next = (flags_reg & ~flag_clr) | flag_set;
	wire irq_any = |(flags_next & flag_en);
	wire wdt_trip = wdt_on & fresh_reg & (cnt_reg[15:8] == cmp_reg[WDT_CH][15:8]);

	// ------------------------------------------------------------
	// apb read mux
	// ------------------------------------------------------------
	always_comb
	begin
		rdata_mux = '0;
		if (hit_ctl)
			rdata_mux = {22'h0, ctrl_reg};
		if (hit_flg)
			rdata_mux = {27'h0, flags_reg};
		if (hit_lo)
			rdata_mux = {24'h0, cnt_reg[7:0]};
		if (hit_hi)
			rdata_mux = {24'h0, snap_reg};
		for (int i = 0; i < NUM_CH; i++)
		begin
			if (hit_md[i])
				rdata_mux = {27'h0, chcfg_reg[i]};
			if (hit_cp[i])
				rdata_mux = {16'h0, cmp_reg[i]};
		end
	end

	// ------------------------------------------------------------
	// registers, bus answer and outputs
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			ctrl_reg      <= CTRL_RST;
			flags_reg     <= FLAGS_RST;
			snap_reg      <= '0;
			prdata        <= '0;
			pready        <= 1'b0;
			pslverr       <= 1'b0;
			irq           <= 1'b0;
			wdt_reset_req <= 1'b0;
		end
		else
		begin
			if (wr & hit_ctl & wdt_on)
				ctrl_reg.watchdog_mode <= pwdata[4];
			else if (wr & hit_ctl)
				ctrl_reg <= pwdata[9:0];
			flags_reg     <= flags_next;
			if (rd_set & hit_lo)
				snap_reg <= cnt_reg[15:8];
			prdata        <= rd_set ? rdata_mux : 32'h0;
			pready        <= setup;
			pslverr       <= setup & ~hit_any;
			irq           <= irq_any;
			wdt_reset_req <= wdt_trip;
		end
	end

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rstn);

	chk_count_step: assert property (advance && !cnt_wr |=> cnt_reg == 16'($past(cnt_reg) + 16'h1))
		else $error("counter did not step by one");
	chk_count_hold: assert property (!advance && !cnt_wr |=> $stable(cnt_reg))
		else $error("counter moved without tick");
	chk_snap_coherent: assert property (rd_set && hit_lo ##1 access ##2 rd_set && hit_hi
		|=> prdata == {24'h0, $past(cnt_reg[15:8], 4)})
		else $error("high byte read not from snapshot");
	chk_read_quiet: assert property (rd_set && advance && !cnt_wr |=> cnt_reg != $past(cnt_reg))
		else $error("read disturbed counting");
	chk_tb_reserved: assert property (ctrl_reg.timebase_select[2:1] == 2'b11 |-> !tick)
		else $error("reserved timebase ticked");
	chk_ext_edge: assert property (ctrl_reg.timebase_select == TB_EXTIN && tick
		|-> !$past(external_count_input, 2) && $past(external_count_input, 3))
		else $error("external tick without falling edge");
	chk_osc_sync: assert property (ctrl_reg.timebase_select == TB_OSC8 && tick
		|-> $past(ext_osc_div8, 2) && !$past(ext_osc_div8, 3))
		else $error("oscillator tick not synchronised");
	chk_cf_wrap: assert property (cf_evt |=> flags_reg.counter_overflow_flag && cnt_reg == 16'h0 || $past(cnt_wr))
		else $error("wrap did not set overflow flag");
	chk_cf_sticky: assert property (flags_reg.counter_overflow_flag
		&& !(wr && hit_flg && pwdata[0]) |=> flags_reg.counter_overflow_flag)
		else $error("overflow flag cleared by itself");
	chk_irq_gate: assert property (!flag_en[0] && flag_en[4:1] == 4'h0 |=> !irq)
		else $error("request with all enables off");
	chk_irq_or: assert property (|(flags_reg & $past(flag_en)) |-> irq)
		else $error("enabled flag gave no request");
	chk_idle_stop: assert property (halted && !cnt_wr |=> $stable(cnt_reg))
		else $error("counter ran in suspended idle");
	chk_idle_run: assert property (cpu_idle && !ctrl_reg.idle_suspend_bit && ctrl_reg.run
		&& tick && !cnt_wr |=> cnt_reg != $past(cnt_reg))
		else $error("counter stopped in idle");
	chk_wdt_lock: assert property (wdt_on && wr && hit_lo && !advance |=> $stable(cnt_reg))
		else $error("counter written in watchdog mode");

	cov_wrap:     cover property (cf_evt ##1 flags_reg.counter_overflow_flag);
	cov_ext_tick: cover property (ctrl_reg.timebase_select == TB_EXTIN && tick);
	cov_snap:     cover property (rd_set && hit_lo ##3 rd_set && hit_hi);
	cov_wdt:      cover property (wdt_reset_req);
endmodule

// ===== pcat_tb.sv
// self-checking testbench for the counter array timebase block
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin n_errors++; $display("[FAIL] t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module tb
	import pcat_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	// ------------------------------------------------------------
	// signals and design instance
	// ------------------------------------------------------------
	logic        sys_clk = 1'b0;
	logic        rstn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        external_count_input;
	logic        ext_osc_div8;
	logic        timer0_overflow;
	logic        cpu_idle;
	logic [2:0]  channel_io_in;
	logic [2:0]  channel_io_out;
	logic [2:0]  channel_io_oe_n;
	logic        irq;
	logic        wdt_reset_req;
	int          n_errors = 0;
	int          check_count = 0;
	// processor side: it takes the request only with both global enables set
	logic        global_irq_enable = 1'b1;
	logic        array_irq_enable = 1'b1;
	wire         cpu_irq_taken = irq & global_irq_enable & array_irq_enable;

	pcat_top u_dut (
		.sys_clk(sys_clk), .rstn(rstn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr),
		.external_count_input(external_count_input), .ext_osc_div8(ext_osc_div8),
		.timer0_overflow(timer0_overflow), .cpu_idle(cpu_idle),
		.channel_io_in(channel_io_in), .channel_io_out(channel_io_out),
		.channel_io_oe_n(channel_io_oe_n), .irq(irq), .wdt_reset_req(wdt_reset_req)
	);

	// 100 ns period
	always #50 sys_clk = ~sys_clk;

	// ------------------------------------------------------------
	// bus and helper tasks
	// ------------------------------------------------------------
	task automatic tally_and_finish();
		if (n_errors == 0 && check_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// one apb transfer; pready and read data taken at the completing rising edge
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] rd, output logic err);
		int n;
		@(posedge sys_clk);
		psel   <= 1'b1;
		pwrite <= wr;
		paddr  <= a;
		pwdata <= wd;
		@(posedge sys_clk);
		penable <= 1'b1;
		for (n = 0; n < 16; n++)
		begin
			@(posedge sys_clk);
			if (pready === 1'b1)
				break;
		end
		if (n == 16)
		begin
			n_errors++;
			tally_and_finish();
		end
		rd  = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] x;
		logic        e;
		apb(1'b1, a, d, x, e);
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		logic e;
		apb(1'b0, a, 32'h0, d, e);
	endtask

	// control word with watchdog mode off
	function automatic logic [31:0] ctl(input logic [2:0] sel, input logic run_en,
		input logic susp, input logic [1:0] ie);
		pcat_ctrl_t c;
		c = CTRL_RST;
		c.watchdog_mode = 1'b0;
		c.timebase_select = sel;
		c.run = run_en;
		c.idle_suspend_bit = susp;
		c.overflow_irq_enable = ie[0];
		c.intermediate_overflow_irq_enable = ie[1];
		return {22'h0, c};
	endfunction

	// stop, then load counter; a write wins over a tick anyway
	task automatic setcnt(input logic [15:0] v);
		wr(OFS_CTRL, ctl(TB_SYS, 1'b0, 1'b0, 2'b00));
		wr(OFS_CNT_LO, {24'h0, v[7:0]});
		wr(OFS_CNT_HI, {24'h0, v[15:8]});
		wr(OFS_FLAGS, 32'h1f);
	endtask

	task automatic settle(input int n);
		repeat (n) @(posedge sys_clk);
		@(negedge sys_clk);
	endtask

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	// watchdog mode after reset blocks counter, ch2 mode and ctrl writes other than the watchdog bit
	task automatic t_reset();
		logic [31:0] d;
		logic        e;
		settle(0);
		`CHK({irq, channel_io_oe_n}, 4'h7)
		rd(OFS_CTRL, d);
		`CHK(d, {22'h0, CTRL_RST})
		rd(OFS_FLAGS, d);
		`CHK(d, 32'h0)
		wr(OFS_CNT_LO, 32'h55);
		rd(OFS_CNT_LO, d);
		`CHK(d, 32'h0)
		wr(OFS_CH_MODE + OFS_CH_STEP + OFS_CH_STEP, 32'h05);
		rd(OFS_CH_MODE + OFS_CH_STEP + OFS_CH_STEP, d);
		`CHK(d, 32'h0)
		wr(OFS_CTRL, 32'h3ff);
		rd(OFS_CTRL, d);
		`CHK(d, {22'h0, CTRL_RST})
		apb(1'b1, 8'h40, 32'h1, d, e);
		`CHK(e, 1'b1)
		apb(1'b0, 8'h40, 32'h0, d, e);
		`CHK({e, d}, {1'b1, 32'h0})
		wr(OFS_CTRL, 32'h0);
		rd(OFS_CTRL, d);
		`CHK(d, 32'h0)
	endtask

	// high byte read returns the snapshot taken by the low byte read
	task automatic t_snapshot();
		logic [31:0] d;
		setcnt(16'h12f0);
		rd(OFS_CNT_LO, d);
		`CHK(d, 32'hf0)
		wr(OFS_CNT_HI, 32'h34);
		rd(OFS_CNT_HI, d);
		`CHK(d, 32'h12)
		rd(OFS_CNT_LO, d);
		rd(OFS_CNT_HI, d);
		`CHK(d, 32'h34)
	endtask

	// count over 48 cycles between two low byte reads
	task automatic span(input logic [2:0] sel, input logic susp, input logic idle,
		input logic [7:0] exp);
		logic [31:0] a;
		logic [31:0] b;
		wr(OFS_CTRL, ctl(sel, 1'b1, susp, 2'b00));
		cpu_idle <= idle;
		rd(OFS_CNT_LO, a);
		for (int i = 0; i < 45; i++)
		begin
			@(posedge sys_clk);
			timer0_overflow      <= (sel == TB_T0OVF) && i[0] && i < 10;
			external_count_input <= (sel != TB_EXTIN) || !i[3]; // falls every 16 cycles
			ext_osc_div8         <= (sel == TB_OSC8) && i[3];
		end
		rd(OFS_CNT_LO, b);
		cpu_idle <= 1'b0;
		`CHK(8'(b[7:0] - a[7:0]), exp)
	endtask

	task automatic t_spans();
		span(TB_SYS, 1'b0, 1'b0, 8'd48);
		span(TB_DIV4, 1'b0, 1'b0, 8'd12);
		span(TB_DIV12, 1'b0, 1'b0, 8'd4);
		span(TB_T0OVF, 1'b0, 1'b0, 8'd5);
		span(TB_EXTIN, 1'b0, 1'b0, 8'd3);
		span(TB_OSC8, 1'b0, 1'b0, 8'd3);
		span(3'h6, 1'b0, 1'b0, 8'd0);
		span(3'h7, 1'b0, 1'b0, 8'd0);
		span(TB_SYS, 1'b1, 1'b1, 8'd0);
		span(TB_SYS, 1'b0, 1'b1, 8'd48);
	endtask

	// wrap sets both overflow flags; enables gate the request
	task automatic t_overflow();
		logic [31:0] d;
		setcnt(16'hfffe);
		wr(OFS_CTRL, ctl(TB_SYS, 1'b1, 1'b0, 2'b00));
		wr(OFS_CTRL, ctl(TB_SYS, 1'b0, 1'b0, 2'b00));
		rd(OFS_FLAGS, d);
		`CHK(d, 32'h03)
		settle(1);
		`CHK(irq, 1'b0)
		wr(OFS_CTRL, ctl(TB_SYS, 1'b0, 1'b0, 2'b01));
		settle(1);
		`CHK(irq, 1'b1)
		`CHK(cpu_irq_taken, 1'b1)
		global_irq_enable <= 1'b0;
		settle(0);
		`CHK(cpu_irq_taken, 1'b0)
		global_irq_enable <= 1'b1;
		array_irq_enable  <= 1'b0;
		settle(0);
		`CHK(cpu_irq_taken, 1'b0)
		array_irq_enable  <= 1'b1;
		rd(OFS_FLAGS, d);
		`CHK(d, 32'h03)
		wr(OFS_FLAGS, 32'h01);
		settle(1);
		`CHK(irq, 1'b0)
		wr(OFS_CTRL, ctl(TB_SYS, 1'b0, 1'b0, 2'b10));
		settle(1);
		`CHK(irq, 1'b1)
		wr(OFS_FLAGS, 32'h02);
		settle(1);
		`CHK(irq, 1'b0)
		rd(OFS_FLAGS, d);
		`CHK(d, 32'h0)
	endtask

	// pwm output on ch0, falling-edge capture on ch1
	task automatic t_channels();
		logic [31:0] d;
		setcnt(16'h0050);
		wr(OFS_CH_CMP, 32'h0100);
		wr(OFS_CH_MODE, {28'h0, CM_PWM16});
		settle(4);
		`CHK({channel_io_oe_n[0], channel_io_out[0]}, 2'b01)
		setcnt(16'h0200);
		settle(4);
		`CHK({channel_io_oe_n[0], channel_io_out[0]}, 2'b00)
		wr(OFS_CH_MODE, {28'h0, CM_OFF});
		wr(OFS_CH_MODE + OFS_CH_STEP, {27'h0, 1'b1, CM_CAP_FALL});
		channel_io_in <= 3'b101;
		settle(8);
		rd(OFS_CH_CMP + OFS_CH_STEP, d);
		`CHK(d, 32'h0200)
		rd(OFS_FLAGS, d);
		`CHK(d, 32'h08)
		settle(1);
		`CHK(irq, 1'b1)
		rd(OFS_FLAGS, d);
		`CHK(d, 32'h08)
		wr(OFS_FLAGS, 32'h08);
		settle(1);
		`CHK(irq, 1'b0)
	endtask

	// soft timer on ch0, pwm8 on ch1, fast toggle on ch2 over one run
	task automatic t_modes();
		logic [31:0] d;
		setcnt(16'h0010);
		wr(OFS_CH_CMP, 32'h0020);
		wr(OFS_CH_MODE, {28'h0, CM_SOFT_TMR});
		wr(OFS_CH_CMP + OFS_CH_STEP, 32'h0018);
		wr(OFS_CH_MODE + OFS_CH_STEP, {28'h0, CM_PWM8});
		wr(OFS_CH_CMP + OFS_CH_STEP + OFS_CH_STEP, 32'h0020);
		wr(OFS_CH_MODE + OFS_CH_STEP + OFS_CH_STEP, {28'h0, CM_FAST_OUT});
		settle(2);
		`CHK({channel_io_oe_n, channel_io_out}, 6'b001010)
		wr(OFS_CTRL, ctl(TB_SYS, 1'b1, 1'b0, 2'b00));
		settle(24);
		wr(OFS_CTRL, ctl(TB_SYS, 1'b0, 1'b0, 2'b00));
		settle(2);
		`CHK({channel_io_oe_n, channel_io_out}, 6'b001100)
		rd(OFS_FLAGS, d);
		`CHK(d, 32'h1c)
	endtask

	// watchdog pulses once the counter high byte meets the ch2 compare high byte
	task automatic t_watchdog();
		int n;
		setcnt(16'h00f0);
		wr(OFS_CH_CMP + OFS_CH_STEP + OFS_CH_STEP, 32'h0100);
		`CHK(wdt_reset_req, 1'b0)
		wr(OFS_CTRL, ctl(TB_SYS, 1'b1, 1'b0, 2'b00) | 32'h10);
		for (n = 0; n < 40; n++)
		begin
			@(posedge sys_clk);
			if (wdt_reset_req === 1'b1)
				break;
		end
		`CHK(n, 17)
	endtask

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial
	begin
		rstn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		external_count_input = 1'b1;
		ext_osc_div8 = 1'b0;
		timer0_overflow = 1'b0;
		cpu_idle = 1'b0;
		channel_io_in = 3'b111;
		repeat (12) @(posedge sys_clk);
		rstn <= 1'b1;
		t_reset();
		t_snapshot();
		t_spans();
		t_overflow();
		t_channels();
		t_modes();
		t_watchdog();
		tally_and_finish();
	end
endmodule
